// File: edu_pkg.sv
// constants and types for the event dispatch unit
package edu_pkg;

	// ************************************************************
	// widths and counts
	// ************************************************************
	localparam int VEC_W = 8;
	localparam int PRI_W = 5;
	localparam int IP_W = 32;
	localparam int CW_W = 32;
	localparam int FT_W = 4;
	localparam int FS_W = 8;
	localparam int NPIN = 4;
	localparam int NBP = 2;
	localparam int NMODE = 6;
	localparam logic [FT_W-1:0] FT_NUM = 4'ha;

	// ************************************************************
	// control word fields
	// ************************************************************
	localparam int PCW_TRC_EN = 0;
	localparam int TCW_MODE_LO = 0;
	localparam int TCW_BP_LO = 16;
	localparam logic [CW_W-1:0] PCW_RST = 32'h0000_0000;
	localparam logic [CW_W-1:0] TCW_RST = 32'h0000_0000;

	// trace event bits, also the trace fault subtype
	localparam int M_INSTR = 0;
	localparam int M_BRANCH = 1;
	localparam int M_CALL = 2;
	localparam int M_RET = 3;
	localparam int M_PRERET = 4;
	localparam int M_SUPV = 5;

	// ************************************************************
	// fault and breakpoint codes
	// ************************************************************
	localparam logic [FT_W-1:0] FT_TRACE = 4'h1;
	localparam logic [FS_W-1:0] BS_HW0 = 8'h01;
	localparam logic [FS_W-1:0] BS_MARK = 8'h10;
	localparam logic [FS_W-1:0] BS_FORCED = 8'h20;

	// cascade handshake pins
	localparam int CASC_REQ = 0;
	localparam int CASC_ACK = 1;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		K_INT = 2'h0,
		K_FLT = 2'h1,
		K_BRK = 2'h2,
		K_TRC = 2'h3
	} edu_kind_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_CALL = 2'h1,
		S_WAIT = 2'h2
	} edu_fsm_t;

	typedef struct packed {
		logic [VEC_W-1:0] vec;
		logic [PRI_W-1:0] pri;
	} edu_irq_t;

	typedef struct packed {
		logic call;
		edu_kind_t kind;
		logic [VEC_W-1:0] idx;
		logic [FS_W-1:0] sub;
		logic [IP_W-1:0] ip;
	} edu_call_t;

	typedef struct packed {
		logic wr;
		edu_irq_t irq;
	} edu_pend_t;

	typedef struct packed {
		logic wr;
		logic [FT_W-1:0] ftype;
		logic [FS_W-1:0] fsub;
		logic [IP_W-1:0] ip;
	} edu_frec_t;

	typedef struct packed {
		logic v;
		logic [FT_W-1:0] ftype;
		logic [FS_W-1:0] fsub;
		logic [IP_W-1:0] ip;
	} edu_flt_t;

	typedef struct packed {
		logic v;
		logic [IP_W-1:0] ip;
		logic mark;
		logic forced_break_instruction;
	} edu_fet_t;

	typedef struct packed {
		logic v;
		logic [NMODE-1:0] ev;
		logic [IP_W-1:0] next_ip;
	} edu_ret_t;

	typedef struct packed {
		edu_fsm_t st;
		logic [CW_W-1:0] pcw;
		logic [CW_W-1:0] tcw;
		logic [NBP-1:0][IP_W-1:0] bp;
		logic [NPIN-1:0] pin_prev;
		logic [NPIN-1:0] preq;
		edu_irq_t [NPIN-1:0] pirq;
		logic msg_v;
		edu_irq_t msg;
		logic msg_rdy;
		logic casc_wait;
		logic casc_ack;
		edu_call_t call;
		edu_pend_t pend;
		edu_frec_t frec;
		logic stall;
		logic resume;
		logic [IP_W-1:0] resume_ip;
	} edu_state_t;

endpackage : edu_pkg

// File: edu_dispatch.sv
// event dispatch unit: interrupts, breakpoints, trace and faults
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Interrupts come from four pins or from bus messages.
// - Two pins can form a request/acknowledge handshake with a cascaded controller.
// - Each interrupt carries a vector and a priority.
// - Priority above the task's is accepted; its vector indexes the interrupt table.
// - Priority below the task's is recorded as pending with vector and priority.
// - Two loadable breakpoint registers fire when the instruction pointer matches.
// - A forced break instruction calls the breakpoint handler with no enable bit but loses to a fault in the same cycle; mark does so only while trace is enabled.
// - Six trace modes, each with its own enable bit.
// - Traced instruction completes first; execution waits for handler, resumes next.
// - Process control word and trace control word, 32 bits each, steer debug.
// - Ten fault types; save pointer and state, then call matching handler.
// - Every fault writes its type into a fault record.
// - Every fault report carries a subtype code.
module edu_dispatch (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// interrupt pins and cascade controller
	input wire logic [edu_pkg::NPIN-1:0] i_irq,
	input wire edu_pkg::edu_irq_t [edu_pkg::NPIN-1:0] i_pin_cfg,
	input wire logic i_casc_en,
	input wire logic [edu_pkg::VEC_W-1:0] i_casc_vec,
	output logic o_casc_ack,
	// interrupt messages from the bus
	input wire logic i_msg_v,
	input wire edu_pkg::edu_irq_t i_msg,
	output logic o_msg_rdy,
	// running task
	input wire logic [edu_pkg::PRI_W-1:0] i_task_pri,
	// debug commands
	input wire logic i_bp_ld,
	input wire logic i_bp_sel,
	input wire logic [edu_pkg::IP_W-1:0] i_bp_val,
	input wire logic i_pcw_ld,
	input wire logic i_tcw_ld,
	input wire logic [edu_pkg::CW_W-1:0] i_cw_val,
	// core events
	input wire edu_pkg::edu_fet_t i_fet,
	input wire edu_pkg::edu_ret_t i_ret,
	input wire edu_pkg::edu_flt_t i_flt,
	input wire logic i_hdl_done,
	// dispatch results
	output edu_pkg::edu_call_t o_call,
	output edu_pkg::edu_pend_t o_pend,
	output edu_pkg::edu_frec_t o_frec,
	output logic o_stall,
	output logic o_resume,
	output logic [edu_pkg::IP_W-1:0] o_resume_ip,
	// control word readback
	output logic [edu_pkg::CW_W-1:0] o_pcw,
	output logic [edu_pkg::CW_W-1:0] o_tcw
);

	// ************************************************************
	// state
	// ************************************************************
	edu_pkg::edu_state_t q;
	edu_pkg::edu_state_t d;
	logic [edu_pkg::NPIN-1:0] rise;
	logic [edu_pkg::FS_W-1:0] bp_sub;
	logic bp_hit;
	logic trc_hit;
	logic irq_v;
	logic irq_msg;
	logic [1:0] irq_pin;
	edu_pkg::edu_irq_t irq;

	// ************************************************************
	// helpers
	// ************************************************************
	// one builder for every handler call keeps the field order in one place
	function automatic edu_pkg::edu_call_t mk_call(
		input edu_pkg::edu_kind_t kind,
		input logic [edu_pkg::VEC_W-1:0] idx,
		input logic [edu_pkg::FS_W-1:0] sub,
		input logic [edu_pkg::IP_W-1:0] ip
	);
		edu_pkg::edu_call_t c;
		c.call = 1'b1;
		c.kind = kind;
		c.idx = idx;
		c.sub = sub;
		c.ip = ip;
		return c;
	endfunction : mk_call

	// fault record builder, shared by real faults and trace events
	function automatic edu_pkg::edu_frec_t mk_frec(
		input logic [edu_pkg::FT_W-1:0] ftype,
		input logic [edu_pkg::FS_W-1:0] fsub,
		input logic [edu_pkg::IP_W-1:0] ip
	);
		edu_pkg::edu_frec_t r;
		r.wr = 1'b1;
		r.ftype = ftype;
		r.fsub = fsub;
		r.ip = ip;
		return r;
	endfunction : mk_frec

	// in cascade mode the two handshake pins carry no interrupts of their own
	function automatic logic casc_owned(
		input int k,
		input logic casc_en
	);
		return casc_en && (k == edu_pkg::CASC_REQ || k == edu_pkg::CASC_ACK);
	endfunction : casc_owned

	// fault and trace handlers sit at the table index of their type
	function automatic logic [edu_pkg::VEC_W-1:0] type_idx(
		input logic [edu_pkg::FT_W-1:0] ftype
	);
		logic [edu_pkg::VEC_W-1:0] v;
		v = '0;
		v[edu_pkg::FT_W-1:0] = ftype;
		return v;
	endfunction : type_idx

	// trace subtype is the set of event bits, widened to the subtype field
	function automatic logic [edu_pkg::FS_W-1:0] ev_sub(
		input logic [edu_pkg::NMODE-1:0] ev
	);
		logic [edu_pkg::FS_W-1:0] s;
		s = '0;
		s[edu_pkg::NMODE-1:0] = ev;
		return s;
	endfunction : ev_sub

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d = q;
		d.call.call = 1'b0;
		d.pend.wr = 1'b0;
		d.frec.wr = 1'b0;
		d.resume = 1'b0;
		d.casc_ack = 1'b0;

		// control words and breakpoint registers
		if (i_pcw_ld) begin
			d.pcw = i_cw_val;
		end
		if (i_tcw_ld) begin
			d.tcw = i_cw_val;
		end
		if (i_bp_ld) begin
			d.bp[i_bp_sel] = i_bp_val;
		end

		// hardware breakpoints only compare while their enable is set
		bp_hit = 1'b0;
		bp_sub = '0;
		for (int b = 0; b < edu_pkg::NBP; b++) begin
			if (i_fet.v && q.tcw[edu_pkg::TCW_BP_LO + b] && i_fet.ip == q.bp[b]) begin
				bp_hit = 1'b1;
				bp_sub = bp_sub | (edu_pkg::BS_HW0 << b);
			end
		end
		if (i_fet.v && i_fet.mark && q.pcw[edu_pkg::PCW_TRC_EN]) begin
			bp_hit = 1'b1;
			bp_sub = bp_sub | edu_pkg::BS_MARK;
		end
		if (i_fet.v && i_fet.forced_break_instruction) begin
			bp_hit = 1'b1;
			bp_sub = bp_sub | edu_pkg::BS_FORCED;
		end

		// trace fires on a retired instruction, after it has completed
		trc_hit = i_ret.v && q.pcw[edu_pkg::PCW_TRC_EN]
			&& |(i_ret.ev & q.tcw[edu_pkg::TCW_MODE_LO +: edu_pkg::NMODE]);

		// pick one interrupt: lowest pin first, then the message slot
		irq_v = 1'b0;
		irq_msg = 1'b0;
		irq_pin = '0;
		irq = q.msg;
		if (q.msg_v) begin
			irq_v = 1'b1;
			irq_msg = 1'b1;
		end
		for (int k = edu_pkg::NPIN - 1; k >= 0; k--) begin
			if (q.preq[k]) begin
				irq_v = 1'b1;
				irq_msg = 1'b0;
				irq_pin = 2'(k);
				irq = q.pirq[k];
			end
		end

		unique case (q.st)
			edu_pkg::S_IDLE: begin
				if (i_flt.v && i_flt.ftype < edu_pkg::FT_NUM) begin
					d.frec = mk_frec(i_flt.ftype, i_flt.fsub, i_flt.ip);
					d.call = mk_call(edu_pkg::K_FLT, type_idx(i_flt.ftype), i_flt.fsub, i_flt.ip);
					d.resume_ip = i_flt.ip;
					d.st = edu_pkg::S_CALL;
					d.stall = 1'b1;
				end else if (bp_hit) begin
					d.call = mk_call(edu_pkg::K_BRK, '0, bp_sub, i_fet.ip);
					d.resume_ip = i_fet.ip;
					d.st = edu_pkg::S_CALL;
					d.stall = 1'b1;
				end else if (trc_hit) begin
					// a trace event is a fault of its own type
					d.frec = mk_frec(edu_pkg::FT_TRACE, ev_sub(i_ret.ev), i_ret.next_ip);
					d.call = mk_call(edu_pkg::K_TRC, type_idx(edu_pkg::FT_TRACE),
						ev_sub(i_ret.ev), i_ret.next_ip);
					d.resume_ip = i_ret.next_ip;
					d.st = edu_pkg::S_CALL;
					d.stall = 1'b1;
				end else if (irq_v) begin
					if (irq_msg) begin
						d.msg_v = 1'b0;
					end else begin
						d.preq[irq_pin] = 1'b0;
					end
					if (irq.pri > i_task_pri) begin
						// vector is the table index of the handler
						d.call = mk_call(edu_pkg::K_INT, irq.vec, '0, '0);
						d.st = edu_pkg::S_CALL;
						d.stall = 1'b1;
					end else begin
						d.pend = '{1'b1, irq};
					end
				end
			end
			edu_pkg::S_CALL: begin
				d.st = edu_pkg::S_WAIT;
			end
			edu_pkg::S_WAIT: begin
				if (i_hdl_done) begin
					d.st = edu_pkg::S_IDLE;
					d.stall = 1'b0;
					d.resume = 1'b1;
				end
			end
			default: begin
				d.st = edu_pkg::S_IDLE;
				d.stall = 1'b0;
			end
		endcase

		// pin capture comes after dispatch so a new edge wins over the clear
		rise = i_irq & ~q.pin_prev;
		d.pin_prev = i_irq;
		for (int k = 0; k < edu_pkg::NPIN; k++) begin
			if (rise[k] && !casc_owned(k, i_casc_en)) begin
				d.preq[k] = 1'b1;
				d.pirq[k] = i_pin_cfg[k];
			end
		end

		// cascade: acknowledge, then take the vector one cycle later
		if (i_casc_en && rise[edu_pkg::CASC_REQ]) begin
			d.casc_ack = 1'b1;
			d.casc_wait = 1'b1;
		end
		if (q.casc_wait) begin
			d.casc_wait = 1'b0;
			d.preq[edu_pkg::CASC_REQ] = 1'b1;
			d.pirq[edu_pkg::CASC_REQ] = '{i_casc_vec, i_pin_cfg[edu_pkg::CASC_REQ].pri};
		end

		// one message slot; ready drops while it is full
		if (i_msg_v && q.msg_rdy) begin
			d.msg_v = 1'b1;
			d.msg = i_msg;
		end
		d.msg_rdy = !d.msg_v;
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '{st: edu_pkg::S_IDLE, pcw: edu_pkg::PCW_RST, tcw: edu_pkg::TCW_RST,
				msg_rdy: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_casc_ack = q.casc_ack;
	assign o_msg_rdy = q.msg_rdy;
	assign o_call = q.call;
	assign o_pend = q.pend;
	assign o_frec = q.frec;
	assign o_stall = q.stall;
	assign o_resume = q.resume;
	assign o_resume_ip = q.resume_ip;
	assign o_pcw = q.pcw;
	assign o_tcw = q.tcw;

endmodule : edu_dispatch

`default_nettype wire

// File: edu_dispatch_assertions.sv
// port assertions for the event dispatch unit
`timescale 1ns/1ps
`default_nettype none
module edu_chk (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// watched ports
	input wire logic [edu_pkg::NPIN-1:0] i_irq,
	input wire logic i_casc_en,
	input wire logic o_casc_ack,
	input wire logic i_msg_v,
	input wire edu_pkg::edu_irq_t i_msg,
	input wire logic o_msg_rdy,
	input wire logic [edu_pkg::PRI_W-1:0] i_task_pri,
	input wire edu_pkg::edu_fet_t i_fet,
	input wire edu_pkg::edu_ret_t i_ret,
	input wire edu_pkg::edu_flt_t i_flt,
	input wire logic i_hdl_done,
	input wire edu_pkg::edu_call_t o_call,
	input wire edu_pkg::edu_pend_t o_pend,
	input wire edu_pkg::edu_frec_t o_frec,
	input wire logic o_stall,
	input wire logic [edu_pkg::CW_W-1:0] o_pcw,
	input wire logic [edu_pkg::CW_W-1:0] o_tcw,
	input wire logic o_resume
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// ************************************************************
	// sequences and properties
	// ************************************************************
	sequence s_flt;
		i_flt.v && i_flt.ftype < edu_pkg::FT_NUM && !o_stall;
	endsequence
	// pins held quiet so no pin request can overtake the message
	sequence s_msg;
		i_msg_v && o_msg_rdy && i_msg.pri > i_task_pri && !o_stall && i_irq == 4'h0
		##1 !o_stall && !i_flt.v && !i_fet.v && !i_ret.v;
	endsequence
	chk_flt_call: assert property (s_flt |=> o_call.call && o_call.kind == edu_pkg::K_FLT
		&& o_call.idx == $past(i_flt.ftype)) else $error("fault call wrong");
	chk_flt_rec: assert property (s_flt |=> o_frec.wr && o_frec.ftype == $past(i_flt.ftype)
		&& o_frec.fsub == $past(i_flt.fsub)) else $error("fault record wrong");
	chk_stall_hold: assert property (o_stall && !i_hdl_done |=> o_stall) else $error("stall dropped");
	chk_resume_next: assert property (o_stall && !o_call.call && i_hdl_done |=> o_resume && !o_stall)
		else $error("no resume");
	chk_forced_brk: assert property (i_fet.v && i_fet.forced_break_instruction && !o_stall && !i_flt.v
		|=> o_call.call && o_call.kind == edu_pkg::K_BRK && (o_call.sub & edu_pkg::BS_FORCED) != 8'h00)
		else $error("forced break missed");
	chk_trace_call: assert property (i_ret.v && o_pcw[0] && (i_ret.ev & o_tcw[5:0]) != 6'h00
		&& !o_stall && !i_flt.v && !i_fet.v
		|=> o_call.call && o_call.kind == edu_pkg::K_TRC && o_call.sub == {2'h0, $past(i_ret.ev)})
		else $error("trace call wrong");
	chk_pend_low: assert property (o_pend.wr |-> o_pend.irq.pri <= $past(i_task_pri))
		else $error("high priority pended");
	chk_msg_call: assert property (s_msg |=> o_call.call && o_call.kind == edu_pkg::K_INT
		&& o_call.idx == $past(i_msg.vec, 2)) else $error("message not dispatched");
	chk_slot_full: assert property (o_msg_rdy && i_msg_v |=> !o_msg_rdy) else $error("slot not busy");
	chk_casc_ack: assert property (i_casc_en && $rose(i_irq[edu_pkg::CASC_REQ]) && !o_casc_ack
		|=> o_casc_ack) else $error("no cascade ack");
endmodule : edu_chk
`default_nettype wire

// File: edu_casc_mdl.sv
// cascaded interrupt controller model
`timescale 1ns/1ps
`default_nettype none
module edu_casc_mdl (
	// clock
	input wire logic i_mclk,
	// handshake
	input wire logic i_ack,
	input wire logic [edu_pkg::VEC_W-1:0] i_vec,
	output logic [edu_pkg::VEC_W-1:0] o_vec
);
	int hold = 0;
	// vector stands two edges past ack, then flips so a late sample shows
	initial begin
		o_vec = 8'h00;
		forever begin
			@(posedge i_mclk);
			#1;
			if (i_ack) begin
				o_vec = i_vec;
				hold = 1;
			end else if (hold > 0) begin
				hold = 0;
			end else begin
				o_vec = ~o_vec;
			end
		end
	end
endmodule : edu_casc_mdl
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the event dispatch unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] i_irq = '0;
	edu_pkg::edu_irq_t [3:0] i_pin_cfg = '0;
	logic i_casc_en = 1'b0;
	logic i_msg_v = 1'b0;
	edu_pkg::edu_irq_t i_msg = '0;
	logic [4:0] i_task_pri = '0;
	logic i_bp_ld = 1'b0, i_bp_sel = 1'b0, i_pcw_ld = 1'b0, i_tcw_ld = 1'b0, i_hdl_done = 1'b0;
	logic [31:0] i_bp_val = '0, i_cw_val = '0;
	edu_pkg::edu_fet_t i_fet = '0;
	edu_pkg::edu_ret_t i_ret = '0;
	edu_pkg::edu_flt_t i_flt = '0;
	logic [7:0] i_casc_vec;
	logic o_casc_ack, o_msg_rdy, o_stall, o_resume;
	edu_pkg::edu_call_t o_call;
	edu_pkg::edu_pend_t o_pend;
	edu_pkg::edu_frec_t o_frec;
	logic [31:0] o_resume_ip, o_pcw, o_tcw;
	int error_cnt = 0;
	int compares = 0;
	logic [7:0] bsub [4] = '{edu_pkg::BS_HW0, edu_pkg::BS_HW0 << 1, edu_pkg::BS_MARK, edu_pkg::BS_FORCED};
	edu_dispatch dut_u (.*);
	edu_casc_mdl casc_u (.i_mclk(i_mclk), .i_ack(o_casc_ack), .i_vec(8'h77), .o_vec(i_casc_vec));
	// ************************************************************
	// tasks
	// ************************************************************
	task step;
		@(posedge i_mclk);
		#1;
	endtask : step
	task check(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task stop_test;
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// sel low waits for a handler call, sel high for a pending write
	task wait_on(input logic sel);
		for (int n = 0; n < 20 && (sel ? o_pend.wr : o_call.call) !== 1'b1; n++) begin
			step;
		end
	endtask : wait_on
	// sub is only paired for breakpoints and trace
	task call_chk(input logic [1:0] k, input logic [7:0] x, input logic [7:0] s);
		wait_on(1'b0);
		check({o_call.call, o_call.kind, o_call.idx}, {1'b1, k, x});
		if (k[1]) begin
			check(o_call.sub, s);
		end
		step;
		i_hdl_done = 1'b1;
		step;
		i_hdl_done = 1'b0;
		check({o_resume, o_stall}, 2'b10);
	endtask : call_chk
	task pend_chk(input logic [12:0] e);
		wait_on(1'b1);
		check({o_pend.wr, o_stall, o_pend.irq}, {2'b10, e});
	endtask : pend_chk
	task quiet;
		repeat (4) begin
			check(o_call.call, 1'b0);
			step;
		end
	endtask : quiet
	task cw_ld(input logic t, input logic [31:0] v);
		i_cw_val = v;
		if (t) begin
			i_tcw_ld = 1'b1;
			step;
			i_tcw_ld = 1'b0;
		end else begin
			i_pcw_ld = 1'b1;
			step;
			i_pcw_ld = 1'b0;
		end
	endtask : cw_ld
	// ************************************************************
	// clock, watchdog and tests
	// ************************************************************
	initial begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	// whole run is about a hundred cycles, so 20 us is a generous ceiling
	initial begin
		#20000;
		error_cnt++;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge i_mclk);
		#1;
		i_rst_n = 1'b1;
		check(o_msg_rdy, 1'b1);
		check(o_pcw, 32'h0000_0000);
		check(o_tcw, 32'h0000_0000);
		cw_ld(1'b0, 32'h0000_0001);
		cw_ld(1'b1, 32'h0003_003f);
		check(o_pcw ^ o_tcw, 32'h0003_003e);
		for (int t = 0; t < 11; t++) begin
			i_flt = {1'b1, 4'(t), 8'(t + 8'h30), 32'h1000 + t};
			step;
			i_flt = '0;
			if (t < 10) begin
				check({o_frec.wr, o_frec.ftype, o_frec.fsub}, {1'b1, 4'(t), 8'(t + 8'h30)});
				check(o_frec.ip, 32'h1000 + t);
				check(o_call.ip, 32'h1000 + t);
				call_chk(2'h1, 8'(t), 8'h00);
				check(o_resume_ip, 32'h1000 + t);
			end else begin
				quiet;
			end
		end
		i_bp_ld = 1'b1;
		for (int b = 0; b < 2; b++) begin
			{i_bp_sel, i_bp_val} = {b[0], 32'h2000 + b};
			step;
		end
		i_bp_ld = 1'b0;
		for (int c = 0; c < 4; c++) begin
			i_fet = {1'b1, (c < 2) ? 32'h2000 + c : 32'h3000, c == 2, c == 3};
			step;
			i_fet = '0;
			call_chk(2'h2, 8'h00, bsub[c]);
		end
		for (int m = 0; m < 6; m++) begin
			i_ret = {1'b1, 6'(1 << m), 32'h4000 + m};
			step;
			i_ret = '0;
			check({o_frec.wr, o_frec.ftype, o_frec.fsub}, {1'b1, edu_pkg::FT_TRACE, 8'(1 << m)});
			check(o_frec.ip, 32'h4000 + m);
			call_chk(2'h3, 8'h01, 8'(1 << m));
			check(o_resume_ip, 32'h4000 + m);
		end
		cw_ld(1'b1, 32'h0000_0000);
		i_ret = {1'b1, 6'h3f, 32'h5000};
		i_fet = {1'b1, 32'h2000, 1'b0, 1'b0};
		step;
		i_ret = '0;
		i_fet = '0;
		quiet;
		i_task_pri = 5'h08;
		for (int p = 0; p < 3; p++) begin
			{i_msg_v, i_msg} = {1'b1, 8'h50 + 8'(p), 5'h09 - 5'(p)};
			step;
			i_msg_v = 1'b0;
			if (p == 0) begin
				call_chk(2'h0, 8'h50, 8'h00);
			end else begin
				pend_chk({8'h50 + 8'(p), 5'h09 - 5'(p)});
			end
		end
		i_pin_cfg = {13'h0863, 13'h085f, 13'h0000, 13'h001f};
		i_irq[2] = 1'b1;
		call_chk(2'h0, 8'h42, 8'h00);
		i_irq[3] = 1'b1;
		pend_chk(13'h0863);
		{i_irq, i_casc_en} = 5'h01;
		step;
		i_irq[0] = 1'b1;
		call_chk(2'h0, 8'h77, 8'h00);
		stop_test;
	end
endmodule : tb_top
bind edu_dispatch edu_chk chk_u (.*);
`default_nettype wire
